// ==== logic/mrc_defs.svh ====
// Constants of the motor relay contact input block
`ifndef MRC_DEFS_SVH
`define MRC_DEFS_SVH

// ----------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------
`define MRC_CLK_HZ          20000000
`define MRC_HOLD_S          11
`define MRC_HOLD_CYCLES     (`MRC_HOLD_S * `MRC_CLK_HZ)
`define MRC_DEB_MS          10
`define MRC_DEB_CYCLES      (`MRC_DEB_MS * (`MRC_CLK_HZ / 1000))
`define MRC_TICK_MS         100
`define MRC_TICK_CYCLES     (`MRC_TICK_MS * (`MRC_CLK_HZ / 1000))

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MRC_OFS_CTRL        8'h00
`define MRC_OFS_SPD_DELAY   8'h04
`define MRC_OFS_ROLE        8'h08
`define MRC_OFS_ADDR        8'h0c
`define MRC_OFS_STATUS      8'h10
`define MRC_OFS_AOUT        8'h14

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define MRC_CTRL_SRC_LSB    0
`define MRC_CTRL_RTD_BIT    2
`define MRC_CTRL_SPECIAL_BIT 3
`define MRC_CTRL_SPD_EN_BIT 4
`define MRC_CTRL_RST        5'h00
`define MRC_SPD_DELAY_RST   8'h32
`define MRC_ROLE_RST        1'h0
`define MRC_ADDR_RST        5'h01
`define MRC_ST_DENIED_BIT   0
`define MRC_ST_DIFF_BIT     1
`define MRC_ST_SPEED_BIT    2
`define MRC_ST_INPUT_LSB    3

// Contact input indexes
`define MRC_IN_RESTART      0
`define MRC_IN_EXT_RESET    1
`define MRC_IN_DIFF         2
`define MRC_IN_SPEED        3
`define MRC_IN_ACCESS       4

// ----------------------------------------------------------------
// Analog output codes, 10 uA per step, and full scales
// ----------------------------------------------------------------
`define MRC_AOUT_ZERO       12'h190
`define MRC_AOUT_SPAN       32'h00000640
`define MRC_AOUT_SAT        12'h7e4
`define MRC_FS_THERMAL      32'h000003e8
`define MRC_FS_CURRENT      32'h00000064
`define MRC_FS_STATOR       32'h000007d0
`define MRC_FS_CT           32'h000003e8

`endif

// ==== logic/mrc_pkg.sv ====
// Types of the motor relay contact input block
package mrc_pkg;

   typedef enum logic [1:0] {
      MRC_SRC_THERMAL,
      MRC_SRC_CURRENT,
      MRC_SRC_STATOR,
      MRC_SRC_CT
   } mrc_src_t;

   typedef enum logic [1:0] {
      MRC_SPD_IDLE,
      MRC_SPD_WAIT,
      MRC_SPD_DONE
   } mrc_spd_state_t;

endpackage

// ==== logic/mrc_debounce.sv ====
// Synchroniser and debouncer for the contact inputs
`timescale 1ns/1ps
module mrc_debounce #(
   parameter int unsigned WIDTH  = 5,
   parameter int unsigned CYCLES = 200000
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Raw contacts and clean results
   input  wire logic [WIDTH-1:0] raw,
   output logic      [WIDTH-1:0] level,
   output logic      [WIDTH-1:0] rise
);
   localparam int unsigned CW = $clog2(CYCLES + 1);

   if (CYCLES < 2) begin : g_chk
      $error("mrc_debounce: CYCLES must be at least 2");
   end

   for (genvar g = 0; g < WIDTH; g++) begin : g_in
      logic          sync1_r;
      logic          sync2_r;
      logic [CW-1:0] cnt_r;
      logic [CW-1:0] cnt_nxt;
      logic          lvl_nxt;
      logic          rise_nxt;

      always_comb begin
         cnt_nxt  = cnt_r;
         lvl_nxt  = level[g];
         rise_nxt = 1'b0;
         if (sync2_r == level[g]) begin
            cnt_nxt = '0;
         end else if (cnt_r == CW'(CYCLES - 1)) begin
            cnt_nxt  = '0;
            lvl_nxt  = sync2_r;
            rise_nxt = sync2_r;
         end else begin
            cnt_nxt = cnt_r + CW'(1);
         end
      end

      always_ff @(posedge clk) begin
         if (rst) begin
            sync1_r  <= 1'b0;
            sync2_r  <= 1'b0;
            cnt_r    <= '0;
            level[g] <= 1'b0;
            rise[g]  <= 1'b0;
         end else begin
            sync1_r  <= raw[g];
            sync2_r  <= sync1_r;
            cnt_r    <= cnt_nxt;
            level[g] <= lvl_nxt;
            rise[g]  <= rise_nxt;
         end
      end
   end
endmodule

// ==== logic/mrc_contact_top.sv ====
// Contact inputs, analog output and link role of the motor relay
//
// Behaviour
// - Emergency restart closure clears thermal memory to zero percent.
// - With temperature input enabled, clearing needs restart held over eleven seconds.
// - Each emergency restart closure lowers starts-per-hour count by one.
// - External reset closure resets the relay like the front-panel key.
// - Special reset option: key spares auxiliary relay one, external reset does not.
// - External reset held closed resets whenever motor conditions permit.
// - Analog output shows one selectable source without touching protection.
// - Zero maps to 4 mA, full scale maps to 20 mA.
// - Values beyond full scale raise the output past 20 mA up to a 20.2 mA limit.
// - Differential input closure trips its assigned relay with no added delay.
// - Differential trip cannot reset until the differential input opens.
// - Speed switch not closed within delay during start trips its relay.
// - Speed switch supervision works only when enabled.
// - Speed switch trip cannot reset until the speed input opens.
// - Access open: values readable, setpoint stores denied with message.
// - A master relay gives no protection; only slaves protect.
// - Master reads slaves; writes slave setpoints only with access closed.
// - Role and address are two separate settings.
// - Master follows one target slave, changing only when the setting changes.
`timescale 1ns/1ps
`include "mrc_defs.svh"
module mrc_contact_top import mrc_pkg::*; #(
   parameter int unsigned DEB_CYCLES  = `MRC_DEB_CYCLES,
   parameter int unsigned HOLD_CYCLES = `MRC_HOLD_CYCLES,
   parameter int unsigned TICK_CYCLES = `MRC_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Contact inputs, high while closed
   input  wire logic        emerg_restart_in,
   input  wire logic        ext_reset_in,
   input  wire logic        diff_in,
   input  wire logic        speed_sw_in,
   input  wire logic        prog_access_in,
   // Motor side
   input  wire logic        key_reset,
   input  wire logic        reset_permit,
   input  wire logic        start_attempt,
   input  wire logic [15:0] q_thermal,
   input  wire logic [15:0] q_current,
   input  wire logic [15:0] q_stator,
   input  wire logic [15:0] q_ct,
   // Protection actions
   output logic             thermal_clear,
   output logic             starts_dec,
   output logic             main_reset,
   output logic             aux1_reset,
   output logic             diff_trip,
   output logic             speed_trip,
   output logic      [11:0] aout_code,
   // Link role
   output logic             protect_en,
   output logic             link_write_en,
   output logic      [4:0]  link_target,
   output logic             link_target_new
);
   localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
   localparam int unsigned TW = $clog2(TICK_CYCLES + 1);

   if (HOLD_CYCLES < 2 || TICK_CYCLES < 2) begin : g_chk
      $error("mrc_contact_top: hold and tick counts must be at least 2");
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   // ----------------------------------------------------------------
   // Contact conditioning
   // ----------------------------------------------------------------
   logic [4:0] in_lvl;
   logic [4:0] in_rise;

   mrc_debounce #(
      .WIDTH  (5),
      .CYCLES (DEB_CYCLES)
   ) u_deb (
      .clk   (clk),
      .rst   (rst),
      .raw   ({prog_access_in, speed_sw_in, diff_in, ext_reset_in, emerg_restart_in}),
      .level (in_lvl),
      .rise  (in_rise)
   );

   logic er_lvl, er_rise, ext_lvl, diff_lvl, spd_lvl, acc_lvl;
   assign er_lvl   = in_lvl[`MRC_IN_RESTART];
   assign er_rise  = in_rise[`MRC_IN_RESTART];
   assign ext_lvl  = in_lvl[`MRC_IN_EXT_RESET];
   assign diff_lvl = in_lvl[`MRC_IN_DIFF];
   assign spd_lvl  = in_lvl[`MRC_IN_SPEED];
   assign acc_lvl  = in_lvl[`MRC_IN_ACCESS];

   // ----------------------------------------------------------------
   // APB registers
   // ----------------------------------------------------------------
   logic [4:0]  ctrl_r,      ctrl_nxt;
   logic [7:0]  spd_dly_r,   spd_dly_nxt;
   logic        role_r,      role_nxt;
   logic [4:0]  addr_r,      addr_nxt;
   logic        denied_r,    denied_nxt;
   logic        tgt_new_nxt;
   logic [31:0] prdata_nxt;
   logic        pslverr_nxt;
   logic        setup, wr_acc, mapped, is_setpt;
   mrc_src_t    src;
   logic        rtd_en, special, spd_en;

   assign src     = mrc_src_t'(ctrl_r[`MRC_CTRL_SRC_LSB +: 2]);
   assign rtd_en  = ctrl_r[`MRC_CTRL_RTD_BIT];
   assign special = ctrl_r[`MRC_CTRL_SPECIAL_BIT];
   assign spd_en  = ctrl_r[`MRC_CTRL_SPD_EN_BIT];
   assign setup   = psel & ~penable;
   // Zero wait: pready rises in the first access cycle
   assign wr_acc  = psel & penable & pready & pwrite;
   assign is_setpt = (paddr == `MRC_OFS_CTRL) || (paddr == `MRC_OFS_SPD_DELAY)
                  || (paddr == `MRC_OFS_ROLE) || (paddr == `MRC_OFS_ADDR);
   assign mapped  = is_setpt || (paddr == `MRC_OFS_STATUS) || (paddr == `MRC_OFS_AOUT);

   always_comb begin
      ctrl_nxt    = ctrl_r;
      spd_dly_nxt = spd_dly_r;
      role_nxt    = role_r;
      addr_nxt    = addr_r;
      denied_nxt  = denied_r;
      tgt_new_nxt = 1'b0;
      if (wr_acc && is_setpt && !acc_lvl) begin
         denied_nxt = 1'b1;
      end else if (wr_acc) begin
         case (paddr)
            `MRC_OFS_CTRL:      ctrl_nxt    = pwdata[4:0];
            `MRC_OFS_SPD_DELAY: spd_dly_nxt = pwdata[7:0];
            `MRC_OFS_ROLE:      role_nxt    = pwdata[0];
            `MRC_OFS_ADDR: begin
               addr_nxt    = pwdata[4:0];
               tgt_new_nxt = role_r && (pwdata[4:0] != addr_r);
            end
            `MRC_OFS_STATUS: begin
               if (pwdata[`MRC_ST_DENIED_BIT]) begin
                  denied_nxt = 1'b0;
               end
            end
            default: ;
         endcase
      end
      prdata_nxt  = '0;
      pslverr_nxt = 1'b0;
      if (setup) begin
         pslverr_nxt = ~mapped;
         case (paddr)
            `MRC_OFS_CTRL:      prdata_nxt = {27'h0000000, ctrl_r};
            `MRC_OFS_SPD_DELAY: prdata_nxt = {24'h000000, spd_dly_r};
            `MRC_OFS_ROLE:      prdata_nxt = {31'h00000000, role_r};
            `MRC_OFS_ADDR:      prdata_nxt = {27'h0000000, addr_r};
            `MRC_OFS_STATUS:    prdata_nxt = {24'h000000, in_lvl, speed_trip,
                                              diff_trip, denied_r};
            `MRC_OFS_AOUT:      prdata_nxt = {20'h00000, aout_code};
            default:            prdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_r          <= `MRC_CTRL_RST;
         spd_dly_r       <= `MRC_SPD_DELAY_RST;
         role_r          <= `MRC_ROLE_RST;
         addr_r          <= `MRC_ADDR_RST;
         denied_r        <= 1'b0;
         link_target_new <= 1'b0;
         prdata          <= '0;
         pready          <= 1'b0;
         pslverr         <= 1'b0;
      end else begin
         ctrl_r          <= ctrl_nxt;
         spd_dly_r       <= spd_dly_nxt;
         role_r          <= role_nxt;
         addr_r          <= addr_nxt;
         denied_r        <= denied_nxt;
         link_target_new <= tgt_new_nxt;
         prdata          <= prdata_nxt;
         pready          <= setup;
         pslverr         <= pslverr_nxt;
      end
   end

   AST_DENIED_KEEP: assert property (wr_acc && is_setpt && !acc_lvl
      |=> denied_r && $stable(ctrl_r) && $stable(role_r) && $stable(addr_r))
      else $error("setpoint store with access open was not refused");

   // ----------------------------------------------------------------
   // Emergency restart and reset
   // ----------------------------------------------------------------
   logic          protect;
   logic [HW-1:0] hold_cnt_r, hold_cnt_nxt;
   logic          hold_done_r, hold_done_nxt;
   logic          tclr_nxt, sdec_nxt, mrst_nxt, arst_nxt, ext_go;

   // A master keeps its contacts readable but acts on nothing
   assign protect = ~role_r;
   assign ext_go  = ext_lvl & reset_permit;

   always_comb begin
      hold_cnt_nxt  = '0;
      hold_done_nxt = 1'b0;
      tclr_nxt      = 1'b0;
      sdec_nxt      = protect & er_rise;
      if (er_lvl && rtd_en) begin
         hold_done_nxt = hold_done_r;
         hold_cnt_nxt  = hold_cnt_r;
         if (!hold_done_r && hold_cnt_r == HW'(HOLD_CYCLES)) begin
            tclr_nxt      = protect;
            hold_done_nxt = 1'b1;
         end else if (!hold_done_r) begin
            hold_cnt_nxt = hold_cnt_r + HW'(1);
         end
      end else if (!rtd_en) begin
         tclr_nxt = protect & er_rise;
      end
      mrst_nxt = protect & (key_reset | ext_go);
      arst_nxt = protect & ((key_reset & ~special) | ext_go);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hold_cnt_r    <= '0;
         hold_done_r   <= 1'b0;
         thermal_clear <= 1'b0;
         starts_dec    <= 1'b0;
         main_reset    <= 1'b0;
         aux1_reset    <= 1'b0;
      end else begin
         hold_cnt_r    <= hold_cnt_nxt;
         hold_done_r   <= hold_done_nxt;
         thermal_clear <= tclr_nxt;
         starts_dec    <= sdec_nxt;
         main_reset    <= mrst_nxt;
         aux1_reset    <= arst_nxt;
      end
   end

   AST_CLEAR_ON_CLOSE: assert property (er_rise && !rtd_en && protect
      |=> thermal_clear)
      else $error("thermal memory not cleared on restart closure");
   AST_CLEAR_AFTER_HOLD: assert property ($rose(thermal_clear) && $past(rtd_en)
      |-> $past(hold_cnt_r) == HW'(HOLD_CYCLES))
      else $error("thermal memory cleared before hold time");
   AST_STARTS_DEC: assert property (er_rise && protect |=> starts_dec ##1 !starts_dec)
      else $error("starts count not lowered exactly once");
   AST_EXT_RESET: assert property (ext_lvl && reset_permit && protect
      |=> main_reset && aux1_reset)
      else $error("external reset did not reset");
   AST_SPECIAL_KEY: assert property (key_reset && special && !ext_go && protect
      |=> main_reset && !aux1_reset)
      else $error("key reset touched auxiliary relay one");
   // A trip latched while still a slave may stay up after the role change
   AST_MASTER_QUIET: assert property (role_r |=> !thermal_clear && !starts_dec
      && !main_reset && !$rose(diff_trip))
      else $error("master relay acted on protection");

   // ----------------------------------------------------------------
   // Differential and speed switch trips
   // ----------------------------------------------------------------
   mrc_spd_state_t spd_st_r, spd_st_nxt;
   logic [TW-1:0]  tick_cnt_r, tick_cnt_nxt;
   logic [7:0]     dly_cnt_r, dly_cnt_nxt;
   logic           start_q_r;
   logic           diff_nxt, spd_trip_nxt;

   always_comb begin
      // Set wins over a reset in the same cycle
      diff_nxt = diff_trip;
      if (protect && diff_lvl) begin
         diff_nxt = 1'b1;
      end else if (main_reset && !diff_lvl) begin
         diff_nxt = 1'b0;
      end
      spd_st_nxt   = spd_st_r;
      tick_cnt_nxt = tick_cnt_r;
      dly_cnt_nxt  = dly_cnt_r;
      spd_trip_nxt = speed_trip;
      if (main_reset && !spd_lvl) begin
         spd_trip_nxt = 1'b0;
      end
      case (spd_st_r)
         MRC_SPD_IDLE: begin
            tick_cnt_nxt = '0;
            dly_cnt_nxt  = spd_dly_r;
            if (start_attempt && !start_q_r && spd_en && protect) begin
               spd_st_nxt = MRC_SPD_WAIT;
            end
         end
         MRC_SPD_WAIT: begin
            if (spd_lvl || !start_attempt) begin
               spd_st_nxt = MRC_SPD_DONE;
            end else if (dly_cnt_r == 8'h00) begin
               spd_trip_nxt = 1'b1;
               spd_st_nxt   = MRC_SPD_DONE;
            end else if (tick_cnt_r == TW'(TICK_CYCLES - 1)) begin
               tick_cnt_nxt = '0;
               dly_cnt_nxt  = dly_cnt_r - 8'h01;
            end else begin
               tick_cnt_nxt = tick_cnt_r + TW'(1);
            end
         end
         MRC_SPD_DONE: begin
            if (!start_attempt) begin
               spd_st_nxt = MRC_SPD_IDLE;
            end
         end
         default: spd_st_nxt = MRC_SPD_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         diff_trip  <= 1'b0;
         speed_trip <= 1'b0;
         spd_st_r   <= MRC_SPD_IDLE;
         tick_cnt_r <= '0;
         dly_cnt_r  <= '0;
         start_q_r  <= 1'b0;
      end else begin
         diff_trip  <= diff_nxt;
         speed_trip <= spd_trip_nxt;
         spd_st_r   <= spd_st_nxt;
         tick_cnt_r <= tick_cnt_nxt;
         dly_cnt_r  <= dly_cnt_nxt;
         start_q_r  <= start_attempt;
      end
   end

   AST_DIFF_NOW: assert property (diff_lvl && protect |=> diff_trip)
      else $error("differential trip not raised at once");
   AST_DIFF_HOLD: assert property (diff_trip && diff_lvl |=> diff_trip)
      else $error("differential trip reset while input closed");
   AST_SPD_TRIP: assert property (spd_st_r == MRC_SPD_WAIT && dly_cnt_r == 8'h00
      && start_attempt && !spd_lvl |=> speed_trip)
      else $error("speed switch trip missing after delay");
   AST_SPD_OFF: assert property (spd_st_r == MRC_SPD_IDLE && !spd_en && !speed_trip
      |=> !speed_trip ##1 !speed_trip)
      else $error("speed trip with supervision disabled");
   AST_SPD_HOLD: assert property (speed_trip && spd_lvl |=> speed_trip)
      else $error("speed trip reset while input closed");

   // ----------------------------------------------------------------
   // Analog output
   // ----------------------------------------------------------------
   logic [15:0] q_sel;
   logic [31:0] fs_sel, scaled;
   logic [11:0] aout_nxt;

   // Source change only steers this path, never the trips
   always_comb begin
      case (src)
         MRC_SRC_THERMAL: begin q_sel = q_thermal; fs_sel = `MRC_FS_THERMAL; end
         MRC_SRC_CURRENT: begin q_sel = q_current; fs_sel = `MRC_FS_CURRENT; end
         MRC_SRC_STATOR:  begin q_sel = q_stator;  fs_sel = `MRC_FS_STATOR;  end
         default:         begin q_sel = q_ct;      fs_sel = `MRC_FS_CT;      end
      endcase
      scaled = ({16'h0000, q_sel} * `MRC_AOUT_SPAN) / fs_sel;
      if (scaled >= 32'({20'h00000, `MRC_AOUT_SAT - `MRC_AOUT_ZERO})) begin
         aout_nxt = `MRC_AOUT_SAT;
      end else begin
         aout_nxt = `MRC_AOUT_ZERO + scaled[11:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         aout_code <= `MRC_AOUT_ZERO;
      end else begin
         aout_code <= aout_nxt;
      end
   end

   AST_AOUT_RANGE: assert property (aout_code >= `MRC_AOUT_ZERO
      && aout_code <= `MRC_AOUT_SAT)
      else $error("analog code outside 4 to 20.2 mA");
   AST_AOUT_ZERO: assert property (q_sel == 16'h0000 |=> aout_code == `MRC_AOUT_ZERO)
      else $error("zero input did not give 4 mA");

   // ----------------------------------------------------------------
   // Link role
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         protect_en    <= 1'b1;
         link_write_en <= 1'b0;
         link_target   <= `MRC_ADDR_RST;
      end else begin
         protect_en    <= protect;
         link_write_en <= role_r & acc_lvl;
         link_target   <= addr_r;
      end
   end

   AST_LINK_WRITE: assert property (link_write_en |-> $past(role_r) && $past(acc_lvl))
      else $error("slave writes allowed without master role and access");
   AST_TARGET_STEADY: assert property ($changed(link_target) |-> $past(addr_r, 2)
      != $past(addr_r))
      else $error("target slave changed with no setting change");
endmodule

// ==== verification/mrc_contacts_model.sv ====
// Contact switch model: each change chatters before it settles
`timescale 1ns/1ps
module mrc_contacts_model (
   // Clock
   input  wire logic       clk,
   // Requested and bouncing contact states
   input  wire logic [4:0] want,
   output logic      [4:0] contact
);
   logic [4:0] prev_r  = 5'h00;
   logic [4:0] mask_r  = 5'h00;
   logic [1:0] bnc_r   = 2'h0;
   // Chatter is shorter than the debounce span, so one closure counts once
   always @(posedge clk) begin
      prev_r <= want;
      if (want != prev_r) begin
         mask_r <= want ^ prev_r;
         bnc_r  <= 2'h3;
      end else if (bnc_r != 2'h0) begin
         bnc_r <= bnc_r - 2'h1;
      end
   end
   assign contact = want ^ (bnc_r[0] ? mask_r : 5'h00);
endmodule

// ==== verification/test_mrc_contact_top.sv ====
// Self-checking testbench of the motor relay contact block
`timescale 1ns/1ps
`include "mrc_defs.svh"
module test_mrc_contact_top;
   logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ev;
   logic        key_reset = 0, reset_permit = 0, start_attempt = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic        pready, pslverr, thermal_clear, starts_dec, main_reset, aux1_reset;
   logic        diff_trip, speed_trip, protect_en, link_write_en, link_target_new;
   logic [4:0]  want = 5'h00, contact, link_target;
   logic [15:0] q_thermal = 16'h0, q_current = 16'h0, q_stator = 16'h0, q_ct = 16'h0;
   logic [11:0] aout_code;
   int          miscompares = 0, comparisons = 0, pc[4] = '{default: 0}, b[4];

   mrc_contact_top #(.DEB_CYCLES(4), .HOLD_CYCLES(50), .TICK_CYCLES(4)) uut (
      .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .emerg_restart_in(contact[0]), .ext_reset_in(contact[1]), .diff_in(contact[2]),
      .speed_sw_in(contact[3]), .prog_access_in(contact[4]), .key_reset, .reset_permit,
      .start_attempt, .q_thermal, .q_current, .q_stator, .q_ct, .thermal_clear, .starts_dec,
      .main_reset, .aux1_reset, .diff_trip, .speed_trip, .aout_code, .protect_en,
      .link_write_en, .link_target, .link_target_new);
   mrc_contacts_model sw (.clk, .want, .contact);

   always #25 clk = ~clk;
   always @(posedge clk) begin
      pc[0] <= pc[0] + thermal_clear;
      pc[1] <= pc[1] + starts_dec;
      pc[2] <= pc[2] + main_reset;
      pc[3] <= pc[3] + aux1_reset;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rv = prdata;
      ev = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic set_c(input int i, input logic v);
      @(posedge clk);
      want[i] <= v;
      cyc(14);
   endtask
   task automatic snap;
      cyc(1);
      b = pc;
   endtask
   task automatic key;
      @(posedge clk);
      key_reset <= 1;
      @(posedge clk);
      key_reset <= 0;
      cyc(3);
   endtask
   task automatic tally_and_finish;
      $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic t_regs;
      chk(aout_code, 12'h190);
      apb(0, `MRC_OFS_SPD_DELAY, 0);
      chk(rv, 32'h32);
      apb(0, `MRC_OFS_ADDR, 0);
      chk(rv, 32'h1);
      apb(0, 8'h18, 0);
      chk(ev, 1'b1);
      $display("regs done");
   endtask
   task automatic t_access;
      apb(1, `MRC_OFS_CTRL, 32'h10);
      apb(0, `MRC_OFS_CTRL, 0);
      chk(rv, 32'h0);
      apb(0, `MRC_OFS_STATUS, 0);
      chk(rv[0], 1'b1);
      set_c(4, 1);
      apb(1, `MRC_OFS_STATUS, 32'h1);
      apb(0, `MRC_OFS_STATUS, 0);
      chk(rv, 32'h80);
      $display("access done");
   endtask
   task automatic t_restart;
      snap;
      set_c(0, 1);
      set_c(0, 0);
      chk(pc[0] - b[0], 1);
      chk(pc[1] - b[1], 1);
      apb(1, `MRC_OFS_CTRL, 32'h4);
      snap;
      set_c(0, 1);
      chk(pc[0] - b[0], 0);
      cyc(60);
      set_c(0, 0);
      chk(pc[0] - b[0], 1);
      chk(pc[1] - b[1], 1);
      $display("restart done");
   endtask
   task automatic t_ext_reset;
      apb(1, `MRC_OFS_CTRL, 32'h8);
      snap;
      key;
      chk(pc[2] - b[2], 1);
      chk(pc[3] - b[3], 0);
      set_c(1, 1);
      snap;
      reset_permit <= 1;
      cyc(5);
      reset_permit <= 0;
      cyc(3);
      chk(pc[2] - b[2], 5);
      chk(pc[3] - b[3], 5);
      set_c(1, 0);
      $display("ext reset done");
   endtask
   task automatic t_diff;
      set_c(2, 1);
      chk(diff_trip, 1'b1);
      key;
      chk(diff_trip, 1'b1);
      set_c(2, 0);
      key;
      chk(diff_trip, 1'b0);
      $display("diff done");
   endtask
   task automatic t_speed;
      apb(1, `MRC_OFS_SPD_DELAY, 32'h2);
      apb(1, `MRC_OFS_CTRL, 32'h10);
      start_attempt <= 1;
      cyc(3);
      chk(speed_trip, 1'b0);
      set_c(3, 1);
      chk(speed_trip, 1'b1);
      key;
      chk(speed_trip, 1'b1);
      set_c(3, 0);
      key;
      chk(speed_trip, 1'b0);
      start_attempt <= 0;
      apb(1, `MRC_OFS_CTRL, 32'h0);
      start_attempt <= 1;
      cyc(20);
      chk(speed_trip, 1'b0);
      start_attempt <= 0;
      $display("speed done");
   endtask
   task automatic t_analog;
      logic [11:0] ex[4] = '{12'h4b0, 12'h4b0, 12'h7e4, 12'h320};
      q_thermal <= 16'd500;
      q_current <= 16'd50;
      q_stator <= 16'd3000;
      q_ct <= 16'd250;
      for (int s = 0; s < 4; s++) begin
         apb(1, `MRC_OFS_CTRL, s);
         cyc(2);
         chk(aout_code, ex[s]);
      end
      apb(0, `MRC_OFS_AOUT, 0);
      chk(rv, 32'h320);
      chk(ev, 1'b0);
      $display("analog done");
   endtask
   task automatic t_role;
      apb(1, `MRC_OFS_ROLE, 32'h1);
      apb(1, `MRC_OFS_ADDR, 32'h7);
      cyc(1);
      chk(link_target_new, 1'b1);
      cyc(1);
      chk(link_target_new, 1'b0);
      chk(protect_en, 1'b0);
      chk(link_write_en, 1'b1);
      chk(link_target, 5'h07);
      snap;
      key;
      chk(pc[2] - b[2], 0);
      set_c(4, 0);
      chk(link_write_en, 1'b0);
      $display("role done");
   endtask

   initial begin
      cyc(6);
      rst <= 0;
      t_regs;
      t_access;
      t_restart;
      t_ext_reset;
      t_diff;
      t_speed;
      t_analog;
      t_role;
      tally_and_finish;
   end
   // Whole run needs well under a thousand cycles
   initial begin
      #1000000;
      miscompares++;
      tally_and_finish;
   end
endmodule
